// ### hw/lsx_map.svh
// Purpose: Constants for the load, store and bit operation execution unit.
// Assumes: One system clock; the register file and data memory are outside.
// Notes: Flag positions follow the usual I T H S V N Z C order from bit 7.
//
// Summary of operation
// RULE1: Post-increment load reads at pointer, then adds one; two cycles, no flags.
// RULE2: Pre-decrement load subtracts one first, then reads at new pointer; two cycles.
// RULE3: Displaced load reads at Y or Z plus q; pointer kept; two cycles.
// RULE4: Direct load reads data memory at constant k; two cycles, flags kept.
// RULE5: Post-increment store writes at X, Y or Z, then adds one; two cycles.
// RULE6: Pre-decrement store subtracts one first, then writes there; two cycles.
// RULE7: Displaced store writes at Y or Z plus q; pointer kept; two cycles.
// RULE8: Direct store writes source register at constant k; two cycles.
// RULE9: Stack save places source register on the stack; two cycles, flags kept.
// RULE10: Stack restore takes stack byte into destination; two cycles, flags kept.
// RULE11: I/O bit set forces bit b of port P high, others kept; two cycles.
// RULE12: I/O bit clear forces bit b of port P low, others kept; two cycles.
// RULE13: Left rotate through carry, updates Z C N V, one cycle.
// RULE14: Right rotate through carry, updates Z C N V, one cycle.
// RULE15: T capture copies source bit b into T only; one cycle.
// RULE16: T insert copies T into destination bit b; flags kept; one cycle.
// RULE17: Sign flag set and clear drive S only; one cycle.
// RULE18: Overflow set and clear drive V only; one cycle.
// RULE19: Half-carry set and clear drive H only; one cycle.
// RULE20: Multi-cycle operations hold off the next instruction through their last cycle.
`ifndef LSX_MAP_SVH
`define LSX_MAP_SVH
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`define FLAG_T 6
`define FLAGS_RESET 8'h00
`define SP_RESET 16'h00df
`define MEM_CYCLES 2
`endif

// ### hw/lsx_pkg.sv
// Purpose: Types for the load, store and bit operation execution unit.
// Assumes: Nothing beyond the header of constants.
// Notes: The opcode set is already decoded into this enumeration.
package lsx_pkg;
    typedef enum logic [4:0] {
        op_nop, indirect_read, displaced_read, direct_read,
        indirect_write, displaced_write, direct_write,
        stack_save, stack_restore, io_bit_set, io_bit_clear,
        rotate_left_carry, rotate_right_carry, flag_t_capture, flag_t_insert,
        sign_flag_set, sign_flag_clear, overflow_flag_set, overflow_flag_clear,
        half_carry_set, half_carry_clear
    } op_type;
    typedef enum logic [1:0] {ptr_x, ptr_y, ptr_z} ptr_sel_type;
    typedef enum logic [1:0] {mode_plain, mode_post_inc, mode_pre_dec} ptr_mode_type;
endpackage

// ### hw/lsx_exec.sv
// Purpose: Executes loads, stores, stack, I/O bit, rotate and flag operations.
// Assumes: Memory answers a read with data in the same cycle as the request.
// Notes: Pointers and stack pointer live here; general registers live outside.
`timescale 1ns/100ps
`default_nettype none
`include "lsx_map.svh"

module lsx_exec #(
    parameter int ADDR_W = 16
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic issue_valid,
    output logic issue_ready,
    input wire lsx_pkg::op_type issue_op,
    input wire lsx_pkg::ptr_sel_type issue_ptr,
    input wire lsx_pkg::ptr_mode_type issue_mode,
    input wire logic [5:0] issue_disp,
    input wire logic [ADDR_W-1:0] issue_addr,
    input wire logic [2:0] issue_bit,
    input wire logic [7:0] src_data,
    input wire logic [7:0] mem_rdata,
    output logic mem_rd,
    output logic mem_wr,
    output logic [ADDR_W-1:0] mem_addr,
    output logic [7:0] mem_wdata,
    output logic io_rd,
    output logic io_wr,
    output logic [5:0] io_addr,
    output logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    output logic rd_we,
    output logic [7:0] rd_data,
    output logic [7:0] flags_register,
    output logic [ADDR_W-1:0] ptr_x_value,
    output logic [ADDR_W-1:0] ptr_y_value,
    output logic [ADDR_W-1:0] ptr_z_value,
    output logic [ADDR_W-1:0] stack_ptr
);
    import lsx_pkg::*;

    // ----------------------------------------------------------------
    // State and pending operation
    // ----------------------------------------------------------------
    typedef enum {st_idle, st_finish} state_type;
    state_type state;
    op_type op_hold;
    logic [2:0] bit_hold;
    logic [5:0] io_hold;
    logic [7:0] io_data_hold;

    // RULE20 hold off issue
    assign issue_ready = (state == st_idle);
    wire take = issue_valid && issue_ready;

    // ----------------------------------------------------------------
    // Address selection
    // ----------------------------------------------------------------
    wire [ADDR_W-1:0] ptr_cur = (issue_ptr == ptr_x) ? ptr_x_value :
                                (issue_ptr == ptr_y) ? ptr_y_value : ptr_z_value;
    wire [ADDR_W-1:0] ptr_inc = ptr_cur + ADDR_W'(1);
    wire [ADDR_W-1:0] ptr_dec = ptr_cur - ADDR_W'(1);
    // RULE2 decrement first
    wire [ADDR_W-1:0] ptr_eff = (issue_mode == mode_pre_dec) ? ptr_dec : ptr_cur;
    // RULE3 pointer plus q
    wire [ADDR_W-1:0] disp_eff = ptr_cur + ADDR_W'(issue_disp);
    wire is_ind = (issue_op == indirect_read) || (issue_op == indirect_write);
    wire is_disp = (issue_op == displaced_read) || (issue_op == displaced_write);
    wire is_dir = (issue_op == direct_read) || (issue_op == direct_write);
    wire is_push = (issue_op == stack_save);
    wire is_pop = (issue_op == stack_restore);
    wire is_io = (issue_op == io_bit_set) || (issue_op == io_bit_clear);
    wire is_rd = (issue_op == indirect_read) || (issue_op == displaced_read) ||
                 (issue_op == direct_read) || is_pop;
    wire is_wr = (issue_op == indirect_write) || (issue_op == displaced_write) ||
                 (issue_op == direct_write) || is_push;
    // RULE4 constant address
    wire [ADDR_W-1:0] next_addr = is_ind ? ptr_eff : is_disp ? disp_eff :
                                  is_dir ? issue_addr : is_push ? stack_ptr :
                                  stack_ptr + ADDR_W'(1);
    wire ptr_upd = take && is_ind && (issue_mode != mode_plain);
    // RULE1 post increment
    wire [ADDR_W-1:0] next_ptr = (issue_mode == mode_post_inc) ? ptr_inc : ptr_dec;

    // ----------------------------------------------------------------
    // Single-cycle data path
    // ----------------------------------------------------------------
    wire c_in = flags_register[`FLAG_C];
    // RULE13 rotate left
    wire [7:0] rol_res = {src_data[6:0], c_in};
    // RULE14 rotate right
    wire [7:0] ror_res = {c_in, src_data[7:1]};
    wire is_rol = (issue_op == rotate_left_carry);
    wire is_rot = is_rol || (issue_op == rotate_right_carry);
    wire [7:0] rot_res = is_rol ? rol_res : ror_res;
    wire rot_c = is_rol ? src_data[7] : src_data[0];
    wire rot_n = rot_res[7];
    wire rot_v = rot_n ^ rot_c;
    // RULE16 T into bit
    wire [7:0] ins_res = (src_data & ~(8'h01 << issue_bit)) |
                         ({7'h00, flags_register[`FLAG_T]} << issue_bit);
    // RULE15 bit into T
    wire cap_bit = src_data[issue_bit];

    logic [7:0] next_flags;
    always_comb begin
        next_flags = flags_register;
        if (take) begin
            unique case (issue_op)
                rotate_left_carry, rotate_right_carry: begin
                    next_flags[`FLAG_C] = rot_c;
                    next_flags[`FLAG_Z] = (rot_res == 8'h00);
                    next_flags[`FLAG_N] = rot_n;
                    next_flags[`FLAG_V] = rot_v;
                    next_flags[`FLAG_S] = rot_n ^ rot_v;
                end
                flag_t_capture: next_flags[`FLAG_T] = cap_bit;
                // RULE17 sign flag
                sign_flag_set: next_flags[`FLAG_S] = 1'b1;
                sign_flag_clear: next_flags[`FLAG_S] = 1'b0;
                // RULE18 overflow flag
                overflow_flag_set: next_flags[`FLAG_V] = 1'b1;
                overflow_flag_clear: next_flags[`FLAG_V] = 1'b0;
                // RULE19 half carry
                half_carry_set: next_flags[`FLAG_H] = 1'b1;
                half_carry_clear: next_flags[`FLAG_H] = 1'b0;
                default: next_flags = flags_register;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Second cycle: read results and I/O write-back
    // ----------------------------------------------------------------
    wire fin = (state == st_finish);
    wire fin_rd = fin && ((op_hold == indirect_read) || (op_hold == displaced_read) ||
                          (op_hold == direct_read) || (op_hold == stack_restore));
    wire fin_io = fin && ((op_hold == io_bit_set) || (op_hold == io_bit_clear));
    // RULE11 set bit
    // RULE12 clear bit
    wire [7:0] io_mask = 8'h01 << bit_hold;
    // The port answers only while its read strobe stands, so the value is kept for the write cycle.
    wire [7:0] io_new = (op_hold == io_bit_set) ? (io_data_hold | io_mask) : (io_data_hold & ~io_mask);

    assign io_rd = take && is_io;
    assign io_wr = fin_io;
    assign io_addr = fin_io ? io_hold : issue_addr[5:0];
    assign io_wdata = io_new;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= st_idle;
            op_hold <= op_nop;
            bit_hold <= 3'h0;
            io_hold <= 6'h00;
            io_data_hold <= 8'h00;
        end else begin
            io_data_hold <= (take && is_io) ? io_rdata : io_data_hold;
            op_hold <= take ? issue_op : op_hold;
            bit_hold <= take ? issue_bit : bit_hold;
            io_hold <= take ? issue_addr[5:0] : io_hold;
            state <= (take && (is_rd || is_wr || is_io)) ? st_finish : st_idle;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            mem_addr <= '0;
            mem_wdata <= 8'h00;
        end else begin
            // RULE5 RULE6 RULE7 RULE8 store issue
            mem_rd <= take && is_rd;
            mem_wr <= take && is_wr;
            mem_addr <= take ? next_addr : mem_addr;
            mem_wdata <= take ? src_data : mem_wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_we <= 1'b0;
            rd_data <= 8'h00;
        end else begin
            // RULE10 restore result
            rd_we <= (take && (is_rot || issue_op == flag_t_insert)) || fin_rd;
            rd_data <= fin_rd ? mem_rdata : is_rot ? rot_res : ins_res;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flags_register <= `FLAGS_RESET;
            ptr_x_value <= '0;
            ptr_y_value <= '0;
            ptr_z_value <= '0;
            stack_ptr <= ADDR_W'(`SP_RESET);
        end else begin
            flags_register <= next_flags;
            ptr_x_value <= (ptr_upd && issue_ptr == ptr_x) ? next_ptr : ptr_x_value;
            ptr_y_value <= (ptr_upd && issue_ptr == ptr_y) ? next_ptr : ptr_y_value;
            ptr_z_value <= (ptr_upd && issue_ptr == ptr_z) ? next_ptr : ptr_z_value;
            // RULE9 stack save
            stack_ptr <= (take && is_push) ? stack_ptr - ADDR_W'(1) :
                         (take && is_pop) ? stack_ptr + ADDR_W'(1) : stack_ptr;
        end
    end

    // ----------------------------------------------------------------
    // Checks: addressing and pointers
    // ----------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    AST_POSTINC_PTR: assert property (take && is_ind && issue_mode == mode_post_inc && issue_ptr == ptr_z // RULE1
        |=> ptr_z_value == $past(ptr_z_value) + ADDR_W'(1) && mem_addr == $past(ptr_z_value))
        else $error("post increment wrong");

    AST_PREDEC_ADDR: assert property (take && is_ind && issue_mode == mode_pre_dec && issue_ptr == ptr_y // RULE2
        |=> mem_addr == ptr_y_value && ptr_y_value == $past(ptr_y_value) - ADDR_W'(1))
        else $error("pre decrement wrong");

    AST_POSTINC_STORE: assert property (take && issue_op == indirect_write && issue_mode == mode_post_inc // RULE5
        && issue_ptr == ptr_x |=> mem_wr && mem_addr == $past(ptr_x_value)
        && ptr_x_value == $past(ptr_x_value) + ADDR_W'(1))
        else $error("post increment store wrong");

    AST_PREDEC_STORE: assert property (take && issue_op == indirect_write && issue_mode == mode_pre_dec // RULE6
        && issue_ptr == ptr_x |=> mem_wr && mem_addr == ptr_x_value
        && ptr_x_value == $past(ptr_x_value) - ADDR_W'(1))
        else $error("pre decrement store wrong");

    AST_DISP_KEEP: assert property (take && is_disp |=> $stable(ptr_y_value) && $stable(ptr_z_value)) // RULE3
        else $error("displaced access moved pointer");

    AST_DISP_READ: assert property (take && issue_op == displaced_read && issue_ptr == ptr_z // RULE3
        |=> mem_rd && mem_addr == $past(ptr_z_value) + ADDR_W'($past(issue_disp)))
        else $error("displaced read address wrong");

    AST_DISP_STORE: assert property (take && issue_op == displaced_write && issue_ptr == ptr_y // RULE7
        |=> mem_wr && mem_addr == $past(ptr_y_value) + ADDR_W'($past(issue_disp)))
        else $error("displaced store address wrong");

    AST_DIRECT_ADDR: assert property (take && is_dir // RULE8
        |=> (mem_rd || mem_wr) && mem_addr == $past(issue_addr))
        else $error("direct address wrong");

    AST_PUSH_SP: assert property (take && is_push // RULE9
        |=> mem_wr && mem_addr == $past(stack_ptr) && stack_ptr == $past(stack_ptr) - ADDR_W'(1))
        else $error("stack save wrong");

    AST_POP_SP: assert property (take && is_pop // RULE10
        |=> mem_rd && stack_ptr == $past(stack_ptr) + ADDR_W'(1) && mem_addr == stack_ptr)
        else $error("stack restore wrong");

    // ----------------------------------------------------------------
    // Checks: timing and I/O bits
    // ----------------------------------------------------------------

    AST_READ_TWO: assert property (take && is_rd // RULE4
        |=> mem_rd ##1 rd_we && issue_ready && rd_data == $past(mem_rdata))
        else $error("read result late");

    AST_WRITE_DATA: assert property (take && is_wr |=> mem_wr && mem_wdata == $past(src_data)) // RULE8
        else $error("store data wrong");

    AST_MEM_FLAGS: assert property (take && (is_rd || is_wr) |=> $stable(flags_register)) // RULE9
        else $error("memory op touched flags");

    AST_HOLD: assert property (take && (is_rd || is_wr || is_io) |=> !issue_ready ##1 issue_ready) // RULE20
        else $error("issue not held one cycle");

    AST_ONE_CYCLE: assert property (take && !(is_rd || is_wr || is_io) |=> issue_ready) // RULE20
        else $error("single cycle op held issue");

    AST_IO_TWO: assert property (take && is_io |-> io_rd ##1 io_wr && !issue_ready) // RULE11
        else $error("io bit op not two cycles");

    AST_IO_SET: assert property (fin_io && op_hold == io_bit_set |-> io_wdata[bit_hold] && io_wr) // RULE11
        else $error("io bit not set");

    AST_IO_CLR: assert property (fin_io && op_hold == io_bit_clear |-> !io_wdata[bit_hold]) // RULE12
        else $error("io bit not cleared");

    AST_IO_KEEP: assert property (fin_io // RULE12
        |-> ((io_wdata ^ $past(io_rdata)) & ~(8'h01 << bit_hold)) == 8'h00)
        else $error("io bit op changed other bits");

    // ----------------------------------------------------------------
    // Checks: register results and flags
    // ----------------------------------------------------------------

    AST_ROL_C: assert property (take && is_rol |=> flags_register[`FLAG_C] == $past(src_data[7]) && rd_we) // RULE13
        else $error("rotate left carry wrong");

    AST_ROL_RES: assert property (take && is_rol // RULE13
        |=> rd_data == {$past(src_data[6:0]), $past(flags_register[`FLAG_C])}
        && flags_register[`FLAG_Z] == (rd_data == 8'h00) && flags_register[`FLAG_N] == rd_data[7])
        else $error("rotate left result wrong");

    AST_ROR_RES: assert property (take && issue_op == rotate_right_carry // RULE14
        |=> rd_we && rd_data == {$past(flags_register[`FLAG_C]), $past(src_data[7:1])}
        && flags_register[`FLAG_C] == $past(src_data[0]))
        else $error("rotate right wrong");

    AST_TCAP: assert property (take && issue_op == flag_t_capture // RULE15
        |=> flags_register[`FLAG_T] == $past(src_data[issue_bit])
        && flags_register[5:0] == $past(flags_register[5:0]))
        else $error("T capture wrong");

    AST_TINS: assert property (take && issue_op == flag_t_insert // RULE16
        |=> rd_we && rd_data[$past(issue_bit)] == flags_register[`FLAG_T] && $stable(flags_register)
        && ((rd_data ^ $past(src_data)) & ~(8'h01 << $past(issue_bit))) == 8'h00)
        else $error("T insert wrong");

    AST_SIGN: assert property (take && (issue_op == sign_flag_set || issue_op == sign_flag_clear) // RULE17
        |=> flags_register[`FLAG_S] == $past(issue_op == sign_flag_set)
        && flags_register[3:0] == $past(flags_register[3:0]))
        else $error("sign flag wrong");

    AST_SV: assert property (take && issue_op == overflow_flag_set // RULE18
        |=> flags_register[`FLAG_V] && flags_register[`FLAG_C] == $past(flags_register[`FLAG_C]))
        else $error("overflow set wrong");

    AST_OVF_CLR: assert property (take && issue_op == overflow_flag_clear // RULE18
        |=> !flags_register[`FLAG_V] && flags_register[2:0] == $past(flags_register[2:0]))
        else $error("overflow clear wrong");

    AST_HALF: assert property (take && (issue_op == half_carry_set || issue_op == half_carry_clear) // RULE19
        |=> flags_register[`FLAG_H] == $past(issue_op == half_carry_set)
        && flags_register[4:0] == $past(flags_register[4:0]))
        else $error("half carry wrong");

    // ----------------------------------------------------------------
    // Cover points
    // ----------------------------------------------------------------

    COV_LOAD: cover property (take && issue_op == indirect_read ##2 rd_we);
    COV_PUSH: cover property (take && is_push);
    COV_IO: cover property (fin_io);
    COV_ROR: cover property (take && issue_op == rotate_right_carry);
endmodule

`default_nettype wire

// ### verification/lsx_mem_model.sv
// Purpose: Data memory and I/O space facing the execution unit.
// Assumes: Memory read data stands in the strobe cycle and the cycle after it; I/O read data only in the strobe cycle.
// Notes: Idle read lines show an inverted value, so stale data cannot match.
`timescale 1ns/100ps
`default_nettype none
module lsx_mem_model (
    input wire logic clk,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata,
    input wire logic io_rd,
    input wire logic io_wr,
    input wire logic [5:0] io_addr,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata
);
    logic [7:0] mem [0:65535];
    logic [7:0] io [0:63];
    logic [7:0] held = 8'h00;
    logic rd_q = 1'b0;
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'(i ^ (i >> 8) ^ 8'h5a);
        end
        for (int i = 0; i < 64; i++) begin
            io[i] = 8'(i * 7 + 1);
        end
    end
    assign mem_rdata = mem_rd ? mem[mem_addr] : (rd_q ? held : ~held);
    assign io_rdata = io_rd ? io[io_addr] : ~io[io_addr];
    always @(posedge clk) begin
        rd_q <= mem_rd;
        if (mem_rd) begin
            held <= mem[mem_addr];
        end
        if (mem_wr) begin
            mem[mem_addr] <= mem_wdata;
        end
        if (io_wr) begin
            io[io_addr] <= io_wdata;
        end
    end
endmodule
`default_nettype wire

// ### verification/load_store_bit_ops_exec_tb.sv
// Purpose: Self-checking bench for the load, store and bit operation unit.
// Assumes: Memory and I/O contents start from a fixed formula.
// Notes: Every operation is followed by idle cycles, so pacing is checked on ready.
`timescale 1ns/100ps
`default_nettype none
`include "lsx_map.svh"
module load_store_bit_ops_exec_tb;
    import lsx_pkg::*;
    // Reset starts high so that the first assertion is a real falling edge.
    logic clk = 1'b0, rst_b = 1'b1, issue_valid = 1'b0, issue_ready, mem_rd, mem_wr, io_rd, io_wr, rd_we;
    op_type issue_op = op_nop;
    ptr_sel_type issue_ptr = ptr_x;
    ptr_mode_type issue_mode = mode_plain;
    logic [5:0] issue_disp = 6'h00, io_addr;
    logic [15:0] issue_addr = 16'h0000, mem_addr, ptr_x_value, ptr_y_value, ptr_z_value, stack_ptr;
    logic [2:0] issue_bit = 3'h0;
    logic [7:0] src_data = 8'h00, mem_rdata, mem_wdata, io_wdata, io_rdata, rd_data, flags_register;
    logic [7:0] sm [0:65535];
    logic [7:0] sio [0:63];
    logic [15:0] ex, ey, ez, esp;
    logic [7:0] ef;
    int err_total = 0, cmp_count = 0, seed = 32'h4808;
    always #2.5 clk = ~clk;
    lsx_exec dut (.clk(clk), .rst_b(rst_b), .issue_valid(issue_valid), .issue_ready(issue_ready),
        .issue_op(issue_op), .issue_ptr(issue_ptr), .issue_mode(issue_mode), .issue_disp(issue_disp),
        .issue_addr(issue_addr), .issue_bit(issue_bit), .src_data(src_data), .mem_rdata(mem_rdata),
        .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .io_rd(io_rd),
        .io_wr(io_wr), .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata), .rd_we(rd_we),
        .rd_data(rd_data), .flags_register(flags_register), .ptr_x_value(ptr_x_value),
        .ptr_y_value(ptr_y_value), .ptr_z_value(ptr_z_value), .stack_ptr(stack_ptr));
    lsx_mem_model mem (.clk(clk), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .io_rd(io_rd), .io_wr(io_wr), .io_addr(io_addr),
        .io_wdata(io_wdata), .io_rdata(io_rdata));
    // ----------------------------------------
    // Checking and reset tasks
    // ----------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic do_reset();
        rst_b <= 1'b0;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        {ex, ey, ez, ef, esp} = {48'h0, `FLAGS_RESET, `SP_RESET};
        #1;
        chk(stack_ptr, esp);
        chk(flags_register, ef);
        chk(issue_ready, 1'b1);
    endtask
    // ----------------------------------------
    // One operation with its expected effects
    // ----------------------------------------
    task automatic do_op(input op_type o, input ptr_sel_type p, input ptr_mode_type m, input logic [5:0] d,
                         input logic [15:0] a, input logic [2:0] b, input logic [7:0] s);
        logic [15:0] pv, ea, np, ga;
        logic [7:0] er, ew, gw, gr;
        logic r, w, iop, wb, sw, sr, sio_seen;
        if (o inside {displaced_read, displaced_write} && p == ptr_x) p = ptr_y;
        if (!(o inside {indirect_read, indirect_write})) m = mode_plain;
        pv = (p == ptr_x) ? ex : (p == ptr_y) ? ey : ez;
        np = (m == mode_post_inc) ? pv + 16'h0001 : (m == mode_pre_dec) ? pv - 16'h0001 : pv;
        ea = (m == mode_pre_dec) ? np : pv;
        if (o inside {displaced_read, displaced_write}) ea = pv + {10'h000, d};
        if (o inside {direct_read, direct_write}) ea = a;
        if (o == stack_save) {ea, esp} = {esp, esp - 16'h0001};
        if (o == stack_restore) {ea, esp} = {esp + 16'h0001, esp + 16'h0001};
        if (p == ptr_x) ex = np;
        if (p == ptr_y) ey = np;
        if (p == ptr_z) ez = np;
        r = o inside {indirect_read, displaced_read, direct_read, stack_restore};
        w = o inside {indirect_write, displaced_write, direct_write, stack_save};
        iop = o inside {io_bit_set, io_bit_clear};
        wb = r || o inside {rotate_left_carry, rotate_right_carry, flag_t_insert};
        er = sm[ea];
        ew = s;
        if (w) sm[ea] = s;
        if (iop) ew = (o == io_bit_set) ? sio[a[5:0]] | (8'h01 << b) : sio[a[5:0]] & ~(8'h01 << b);
        if (iop) sio[a[5:0]] = ew;
        case (o)
            rotate_left_carry: {er, ef[`FLAG_C]} = {s[6:0], ef[`FLAG_C], s[7]};
            rotate_right_carry: {er, ef[`FLAG_C]} = {ef[`FLAG_C], s};
            flag_t_capture: ef[`FLAG_T] = s[b];
            flag_t_insert: begin
                er = s;
                er[b] = ef[`FLAG_T];
            end
            sign_flag_set, sign_flag_clear: ef[`FLAG_S] = (o == sign_flag_set);
            overflow_flag_set, overflow_flag_clear: ef[`FLAG_V] = (o == overflow_flag_set);
            half_carry_set, half_carry_clear: ef[`FLAG_H] = (o == half_carry_set);
            default: ;
        endcase
        if (o inside {rotate_left_carry, rotate_right_carry}) begin
            {ef[`FLAG_Z], ef[`FLAG_N]} = {er == 8'h00, er[7]};
            ef[`FLAG_V] = er[7] ^ ef[`FLAG_C];
            ef[`FLAG_S] = er[7] ^ ef[`FLAG_V];
        end
        @(posedge clk);
        {issue_valid, issue_op, issue_ptr, issue_mode} <= {1'b1, o, p, m};
        {issue_disp, issue_addr, issue_bit, src_data} <= {d, a, b, s};
        #1;
        if (iop) chk({io_rd, 2'b00, io_addr}, {1'b1, 2'b00, a[5:0]});
        @(posedge clk);
        issue_valid <= 1'b0;
        {sw, sr, sio_seen, ga, gw, gr} = '0;
        for (int n = 0; n < 3; n++) begin
            #1;
            if (n == 0) chk(issue_ready, !(r || w || iop));
            if (n == 1) chk(issue_ready, 1'b1);
            if (mem_rd || mem_wr) {ga, gw, sw} = {mem_addr, mem_wdata, mem_wr};
            if (io_wr) {sio_seen, gw} = {1'b1, io_wdata};
            if (rd_we) {sr, gr} = {1'b1, rd_data};
            @(posedge clk);
        end
        chk(sr, wb);
        if (sr) chk(gr, er);
        if (r || w) chk(ga, ea);
        if (w || iop) chk(gw, ew);
        chk({sw, sio_seen}, {w, iop});
        chk(flags_register, ef);
        chk(ptr_x_value, ex);
        chk(ptr_y_value, ey);
        chk(ptr_z_value, ez);
        chk(stack_ptr, esp);
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        for (int i = 0; i < 65536; i++) sm[i] = 8'(i ^ (i >> 8) ^ 8'h5a);
        for (int i = 0; i < 64; i++) sio[i] = 8'(i * 7 + 1);
        do_reset();
        do_op(indirect_read, ptr_x, mode_pre_dec, 6'h00, 16'h0000, 3'h0, 8'h00);
        do_op(displaced_write, ptr_z, mode_plain, 6'h3f, 16'h0000, 3'h0, 8'ha5);
        do_op(displaced_read, ptr_z, mode_plain, 6'h3f, 16'h0000, 3'h0, 8'h00);
        for (int k = 1; k <= 20; k++) begin
            for (int j = 0; j < 3; j++) do_op(op_type'(k), ptr_sel_type'(j), ptr_mode_type'(j),
                6'($random(seed)), 16'($random(seed)), 3'($random(seed)), 8'($random(seed)));
        end
        for (int i = 0; i < 400; i++) begin
            if (i == 200) do_reset();
            do_op(op_type'(($random(seed) & 32'h7fffffff) % 20 + 1), ptr_sel_type'(($random(seed) & 3) % 3),
                ptr_mode_type'(($random(seed) & 3) % 3), 6'($random(seed)), 16'($random(seed)),
                3'($random(seed)), 8'($random(seed)));
        end
        wrap_up();
    end
    initial begin
        #200000;
        err_total++;
        wrap_up();
    end
endmodule
`default_nettype wire
